// *** src/pwm_timer.sv ***
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] Unbuffered compare uses the channel value as it stands, effective at once.
// [RULE2] Unsynchronised rewrites may miss compares for two periods; not guarded.
// [RULE3] Channel compare match raises the channel event and its request.
// [RULE4] Counter period completion raises the overflow event and its request.
// [RULE5] Software writes smaller values on compare, larger on overflow.
// [RULE6] Link bit on channel 0 joins both channels onto the channel 0 pin.
// [RULE7] After linking, channel 0 value controls until channel 1 written and overflow.
// [RULE8] At each overflow control passes to the value pair written last.
// [RULE9] Linked: channel 0 control rules, channel 1 control ignored, its pin released.
// [RULE10] Writing the active value pair while linked acts at once.
// [RULE11] Toggle-on-overflow toggles the pin when the counter hits the period limit.
// [RULE12] Pulse runs overflow to compare; clear gives high pulse, set low pulse.
// [RULE13] Period is period limit plus one prescaled clocks.
// [RULE14] Duty equals compare value over period count.
// [RULE15] Mode code 0:1 unbuffered, 1:0 buffered compare or PWM.
// [RULE16] Edge code 1:0 clears, 1:1 sets the pin on compare.
// [RULE17] Software initialises: halt, reset, period, width, mode bits, then run.
// [RULE18] Link bit takes precedence over the low mode bit.
// [RULE19] Without toggle-on-overflow the pin never toggles, giving zero duty; here the set edge code holds the pin high instead.
// [RULE20] Full duty force with toggle-on-overflow holds the pin at full duty.
// [RULE21] Software should not use toggle-on-compare for PWM.
// [RULE22] Overflow sets the overflow flag; request when its enable is set.
// [RULE23] Each channel compare sets its flag; request when its enable is set.
// [RULE24] Counter reset bit clears counter and prescaler, self-clears, reads zero.
// [RULE25] Counter wraps to zero after the limit and holds while halted.
module pwm_timer #(
   parameter int CNT_W = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan0_pin,
   output logic chan0_pin_oe,
   output logic chan1_pin,
   output logic chan1_pin_oe,
   output logic overflow_irq,
   output logic [1:0] chan_irq
);
   if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must lie between 8 and 16");
   end

   // Control and status
   logic overflow_flag;
   logic ovf_arm;
   logic overflow_irq_enable;
   logic counter_halt;
   logic [2:0] prescale_sel;
   logic [CNT_W-1:0] period_limit_pair;
   logic [CNT_W-1:0] count;
   logic [timer_pkg::PRE_W-1:0] pre_cnt;
   logic [timer_pkg::PRE_W-1:0] pre_mask;
   logic tick;
   logic at_limit;
   logic ovf_event;
   logic [CNT_W-1:0] next_count;

   // Channel state
   logic link_buffered_mode_bit;
   logic [1:0] chan_event_flag;
   logic [1:0] chan_arm;
   logic [1:0] chan_irq_enable;
   logic [1:0] chan_mode_low_bit;
   logic [1:0] chan_edge_level_high;
   logic [1:0] chan_edge_level_low;
   logic [1:0] toggle_on_overflow;
   logic [1:0] full_duty_force;
   logic [CNT_W-1:0] chan_value_pair [2];
   logic active_sel;
   logic last_written;
   logic next_last;

   // Bus decode
   logic access;
   logic wr;
   logic rd;
   logic addr_ok;
   logic [31:0] rd_word;
   logic wr_ctrl;
   logic wr_period;
   logic [1:0] wr_ch_ctrl;
   logic [1:0] wr_ch_val;
   logic [1:0] rd_ch_ctrl;
   logic rd_ctrl;
   logic cnt_reset;

   chan_if #(.CNT_W(CNT_W)) ch_if [2] ();

   assign access = psel && penable;
   assign wr = access && pwrite && addr_ok;
   assign rd = access && !pwrite && addr_ok;
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok;

   always_comb begin
      rd_word = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         timer_pkg::OFS_TIMER_CTRL: begin
            rd_word[timer_pkg::BIT_OVF_FLAG] = overflow_flag;
            rd_word[timer_pkg::BIT_OVF_IE] = overflow_irq_enable;
            rd_word[timer_pkg::BIT_HALT] = counter_halt;
            rd_word[timer_pkg::PS_MSB:timer_pkg::PS_LSB] = prescale_sel;
         end
         timer_pkg::OFS_COUNTER: rd_word[CNT_W-1:0] = count;
         timer_pkg::OFS_PERIOD: rd_word[CNT_W-1:0] = period_limit_pair;
         timer_pkg::OFS_CH0_CTRL, timer_pkg::OFS_CH1_CTRL: begin
            // Address bit 4 tells the two channel words apart; channel 0 view reports the linked function
            rd_word[timer_pkg::BIT_CH_FLAG] = chan_event_flag[paddr[4]]; // [RULE9]
            rd_word[timer_pkg::BIT_CH_IE] = chan_irq_enable[paddr[4]];
            rd_word[timer_pkg::BIT_MODE_HIGH] = !paddr[4] && link_buffered_mode_bit;
            rd_word[timer_pkg::BIT_MODE_LOW] = chan_mode_low_bit[paddr[4]];
            rd_word[timer_pkg::EDGE_MSB] = chan_edge_level_high[paddr[4]];
            rd_word[timer_pkg::EDGE_LSB] = chan_edge_level_low[paddr[4]];
            rd_word[timer_pkg::BIT_TOV] = toggle_on_overflow[paddr[4]];
            rd_word[timer_pkg::BIT_FULL] = full_duty_force[paddr[4]];
         end
         timer_pkg::OFS_CH0_VALUE: rd_word[CNT_W-1:0] = chan_value_pair[0];
         timer_pkg::OFS_CH1_VALUE: rd_word[CNT_W-1:0] = chan_value_pair[1];
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      wr_ctrl = wr && paddr == timer_pkg::OFS_TIMER_CTRL;
      rd_ctrl = rd && paddr == timer_pkg::OFS_TIMER_CTRL;
      wr_period = wr && paddr == timer_pkg::OFS_PERIOD;
      wr_ch_ctrl[0] = wr && paddr == timer_pkg::OFS_CH0_CTRL;
      wr_ch_ctrl[1] = wr && paddr == timer_pkg::OFS_CH1_CTRL;
      rd_ch_ctrl[0] = rd && paddr == timer_pkg::OFS_CH0_CTRL;
      rd_ch_ctrl[1] = rd && paddr == timer_pkg::OFS_CH1_CTRL;
      wr_ch_val[0] = wr && paddr == timer_pkg::OFS_CH0_VALUE;
      wr_ch_val[1] = wr && paddr == timer_pkg::OFS_CH1_VALUE;
      cnt_reset = wr_ctrl && pwdata[timer_pkg::BIT_CNT_RESET];
   end

   // Read data is latched in the setup cycle so prdata comes from a flop
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_word;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_irq_enable <= 1'b0;
         counter_halt <= timer_pkg::RST_HALT;
         prescale_sel <= 3'h0;
      end else if (wr_ctrl) begin
         overflow_irq_enable <= pwdata[timer_pkg::BIT_OVF_IE];
         counter_halt <= pwdata[timer_pkg::BIT_HALT];
         prescale_sel <= pwdata[timer_pkg::PS_MSB:timer_pkg::PS_LSB];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         period_limit_pair <= timer_pkg::RST_PERIOD[CNT_W-1:0];
      end else if (wr_period) begin
         period_limit_pair <= pwdata[CNT_W-1:0];
      end
   end

   // Prescaler: divide by 2**sel; the external clock code gives no ticks here
   assign pre_mask = ~({timer_pkg::PRE_W{1'b1}} << prescale_sel);
   assign tick = !counter_halt && prescale_sel != timer_pkg::PS_EXTERNAL && (pre_cnt & pre_mask) == pre_mask;
   assign at_limit = count == period_limit_pair;
   assign ovf_event = tick && at_limit; // [RULE4] [RULE13]
   assign next_count = at_limit ? '0 : CNT_W'(count + 1'b1); // [RULE25]

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= '0;
      end else if (cnt_reset) begin
         pre_cnt <= '0; // [RULE24]
      end else if (!counter_halt) begin
         pre_cnt <= pre_cnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (cnt_reset) begin
         count <= '0; // [RULE24]
      end else if (tick) begin
         count <= next_count; // [RULE13] [RULE25]
      end
   end

   // Flag clears only after a read that saw it set; a new event wins over the clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
         ovf_arm <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag <= 1'b1; // [RULE22]
         ovf_arm <= 1'b0;
      end else if (wr_ctrl) begin
         if (ovf_arm && !pwdata[timer_pkg::BIT_OVF_FLAG]) begin
            overflow_flag <= 1'b0;
         end
         ovf_arm <= 1'b0;
      end else if (rd_ctrl && prdata[timer_pkg::BIT_OVF_FLAG]) begin
         ovf_arm <= 1'b1;
      end
   end

   assign overflow_irq = overflow_flag && overflow_irq_enable; // [RULE4] [RULE22]

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         link_buffered_mode_bit <= 1'b0;
      end else if (wr_ch_ctrl[0]) begin
         link_buffered_mode_bit <= pwdata[timer_pkg::BIT_MODE_HIGH]; // [RULE6]
      end
   end

   // Buffered select: last write picks, switch lands only on overflow
   always_comb begin
      next_last = last_written;
      if (wr_ch_val[1]) begin
         next_last = 1'b1;
      end else if (wr_ch_val[0]) begin
         next_last = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         last_written <= 1'b0;
         active_sel <= 1'b0;
      end else if (!link_buffered_mode_bit) begin
         last_written <= 1'b0; // [RULE7]
         active_sel <= 1'b0;
      end else begin
         last_written <= next_last;
         if (ovf_event) begin
            active_sel <= next_last; // [RULE8]
         end
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_chan
      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            chan_irq_enable[i] <= 1'b0;
            chan_mode_low_bit[i] <= 1'b0;
            chan_edge_level_high[i] <= 1'b0;
            chan_edge_level_low[i] <= 1'b0;
            toggle_on_overflow[i] <= 1'b0;
            full_duty_force[i] <= 1'b0;
         end else if (wr_ch_ctrl[i]) begin
            chan_irq_enable[i] <= pwdata[timer_pkg::BIT_CH_IE];
            chan_mode_low_bit[i] <= pwdata[timer_pkg::BIT_MODE_LOW];
            chan_edge_level_high[i] <= pwdata[timer_pkg::EDGE_MSB];
            chan_edge_level_low[i] <= pwdata[timer_pkg::EDGE_LSB];
            toggle_on_overflow[i] <= pwdata[timer_pkg::BIT_TOV];
            full_duty_force[i] <= pwdata[timer_pkg::BIT_FULL];
         end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            chan_value_pair[i] <= '0;
         end else if (wr_ch_val[i]) begin
            chan_value_pair[i] <= pwdata[CNT_W-1:0]; // [RULE10]
         end
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
         if (!nrst) begin
            chan_event_flag[i] <= 1'b0;
            chan_arm[i] <= 1'b0;
         end else if (ch_if[i].hit) begin
            chan_event_flag[i] <= 1'b1; // [RULE3] [RULE23]
            chan_arm[i] <= 1'b0;
         end else if (wr_ch_ctrl[i]) begin
            if (chan_arm[i] && !pwdata[timer_pkg::BIT_CH_FLAG]) begin
               chan_event_flag[i] <= 1'b0;
            end
            chan_arm[i] <= 1'b0;
         end else if (rd_ch_ctrl[i] && prdata[timer_pkg::BIT_CH_FLAG]) begin
            chan_arm[i] <= 1'b1;
         end
      end

      assign chan_irq[i] = chan_event_flag[i] && chan_irq_enable[i]; // [RULE3] [RULE23]

      assign ch_if[i].ovf = ovf_event;
      assign ch_if[i].cnt_tick = tick;
      assign ch_if[i].count_next = next_count;
      assign ch_if[i].edge_sel = {chan_edge_level_high[i], chan_edge_level_low[i]};
      assign ch_if[i].tov = toggle_on_overflow[i];
      assign ch_if[i].full_duty = full_duty_force[i];
      if (i == 0) begin : g_lead
         // Link bit alone enables buffered mode, whatever the low bit says
         assign ch_if[i].enable = link_buffered_mode_bit || chan_mode_low_bit[0]; // [RULE15] [RULE18]
         assign ch_if[i].compare_value = (link_buffered_mode_bit && active_sel) ?
            chan_value_pair[1] : chan_value_pair[0]; // [RULE8] [RULE10] [RULE14]
      end else begin : g_follow
         assign ch_if[i].enable = !link_buffered_mode_bit && chan_mode_low_bit[1]; // [RULE9] [RULE15]
         assign ch_if[i].compare_value = chan_value_pair[1];
      end

      pwm_channel u_chan (
         .ref_clk(ref_clk),
         .nrst(nrst),
         .io(ch_if[i])
      );
   end

   assign chan0_pin = ch_if[0].pin;
   assign chan0_pin_oe = ch_if[0].pin_oe; // [RULE6]
   assign chan1_pin = ch_if[1].pin;
   assign chan1_pin_oe = ch_if[1].pin_oe; // [RULE9]

   a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE25]
      tick && at_limit && !cnt_reset |=> count == '0)
      else $error("counter did not wrap to zero");
   a_halt_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE25]
      counter_halt && !cnt_reset |=> $stable(count))
      else $error("counter moved while halted");
   a_reset_bit: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE24]
      cnt_reset |=> count == '0 && pre_cnt == '0 && !prdata[timer_pkg::BIT_CNT_RESET])
      else $error("counter reset bit failed");
   a_ovf_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE22]
      ovf_event |=> overflow_flag ##0 (overflow_irq == overflow_irq_enable))
      else $error("overflow flag or request missing");
   a_chan_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE23]
      ch_if[0].hit |=> chan_event_flag[0] && (chan_irq[0] == chan_irq_enable[0]))
      else $error("channel flag or request missing");
   a_link_switch: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE8]
      link_buffered_mode_bit && ovf_event && $past(link_buffered_mode_bit) |=> active_sel == $past(next_last))
      else $error("buffered select missed overflow");
   a_link_release: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE9]
      link_buffered_mode_bit |-> !chan1_pin_oe && !ch_if[1].hit)
      else $error("channel 1 active while linked");
   a_link_start: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE7]
      $rose(link_buffered_mode_bit) |-> !active_sel ##1 (active_sel == 1'b0) [*1])
      else $error("linked start not on channel 0 value");
   a_buffer_pick: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE18]
      link_buffered_mode_bit && tick && next_count == (active_sel ? chan_value_pair[1] : chan_value_pair[0])
         |-> ch_if[0].hit)
      else $error("buffered channel not in control");
endmodule
`default_nettype wire

// *** src/timer_pkg.sv ***
package timer_pkg;
   // Register byte offsets on the APB word map
   localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
   localparam logic [7:0] OFS_COUNTER = 8'h04;
   localparam logic [7:0] OFS_PERIOD = 8'h08;
   localparam logic [7:0] OFS_CH0_CTRL = 8'h0C;
   localparam logic [7:0] OFS_CH0_VALUE = 8'h10;
   localparam logic [7:0] OFS_CH1_CTRL = 8'h14;
   localparam logic [7:0] OFS_CH1_VALUE = 8'h18;

   // timer_ctrl_status fields
   localparam int BIT_OVF_FLAG = 7;
   localparam int BIT_OVF_IE = 6;
   localparam int BIT_HALT = 5;
   localparam int BIT_CNT_RESET = 4;
   localparam int PS_MSB = 2;
   localparam int PS_LSB = 0;

   // chan_ctrl_status fields
   localparam int BIT_CH_FLAG = 7;
   localparam int BIT_CH_IE = 6;
   localparam int BIT_MODE_HIGH = 5;
   localparam int BIT_MODE_LOW = 4;
   localparam int EDGE_MSB = 3;
   localparam int EDGE_LSB = 2;
   localparam int BIT_TOV = 1;
   localparam int BIT_FULL = 0;

   // Reset values
   localparam logic RST_HALT = 1'b1;
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;

   // Encodings
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_TOGGLE = 2'h1;
   localparam logic [1:0] EDGE_CLEAR = 2'h2;
   localparam logic [1:0] EDGE_SET = 2'h3;
   localparam logic [2:0] PS_EXTERNAL = 3'h7;
   localparam int PRE_W = 6;
endpackage

// *** src/chan_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface chan_if #(parameter int CNT_W = 16) ();
   logic ovf;
   logic cnt_tick;
   logic [CNT_W-1:0] count_next;
   logic [CNT_W-1:0] compare_value;
   logic enable;
   logic [1:0] edge_sel;
   logic tov;
   logic full_duty;
   logic hit;
   logic pin;
   logic pin_oe;
   modport timer (output ovf, cnt_tick, count_next, compare_value, enable, edge_sel, tov, full_duty,
                  input hit, pin, pin_oe);
   modport chan (input ovf, cnt_tick, count_next, compare_value, enable, edge_sel, tov, full_duty,
                 output hit, pin, pin_oe);
endinterface
`default_nettype wire

// *** src/pwm_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwm_channel (
   input wire logic ref_clk,
   input wire logic nrst,
   chan_if.chan io
);
   logic next_pin;

   // Compare sees the live value, so a rewrite acts at once
   assign io.hit = io.enable && io.cnt_tick && (io.count_next == io.compare_value); // [RULE1] [RULE2]
   assign io.pin_oe = io.enable && (io.edge_sel != timer_pkg::EDGE_NONE);

   always_comb begin
      next_pin = io.pin;
      if (io.ovf && io.tov) begin
         next_pin = ~io.pin; // [RULE11] [RULE19]
      end
      // Compare is applied after the overflow toggle so a zero value stays at zero duty
      if (io.hit) begin
         case (io.edge_sel)
            timer_pkg::EDGE_CLEAR: next_pin = 1'b0; // [RULE12] [RULE16]
            timer_pkg::EDGE_SET: next_pin = 1'b1; // [RULE12] [RULE16]
            timer_pkg::EDGE_TOGGLE: next_pin = ~next_pin;
            default: next_pin = next_pin;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         io.pin <= 1'b0;
      end else if (!io.enable) begin
         io.pin <= 1'b0;
      end else if (io.full_duty && io.tov) begin
         io.pin <= ~io.edge_sel[0]; // [RULE20]
      end else begin
         io.pin <= next_pin;
      end
   end

   a_clear_on_hit: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE16]
      io.enable && io.hit && io.edge_sel == timer_pkg::EDGE_CLEAR && !(io.full_duty && io.tov) |=> !io.pin)
      else $error("pin not cleared on compare");
   a_set_on_hit: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE12]
      io.enable && io.hit && io.edge_sel == timer_pkg::EDGE_SET && !(io.full_duty && io.tov) |=> io.pin)
      else $error("pin not set on compare");
   a_tov_toggle: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE11]
      io.enable && io.ovf && io.tov && !io.hit && !io.full_duty |=> io.pin != $past(io.pin))
      else $error("pin did not toggle on overflow");
   a_no_tov_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE19]
      io.enable && !io.tov && !io.hit && $past(io.enable) |=> $stable(io.pin))
      else $error("pin moved without toggle enable");
   a_full_duty_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // [RULE20]
      (io.enable && io.full_duty && io.tov) [*2] |-> io.pin != io.edge_sel[0])
      else $error("full duty level not held");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic chan0_pin;
   logic chan0_pin_oe;
   logic chan1_pin;
   logic chan1_pin_oe;
   logic overflow_irq;
   logic [1:0] chan_irq;
   logic [31:0] rd;
   logic err;
   int n_errors = 0;
   int comparisons = 0;
   int per;
   int v0;
   int v1;
   int h0;
   int h1;
   int span;
   logic [7:0] ctl;

   always #10 ref_clk = ~ref_clk;

   pwm_timer #(.CNT_W(16)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chan0_pin(chan0_pin), .chan0_pin_oe(chan0_pin_oe), .chan1_pin(chan1_pin),
      .chan1_pin_oe(chan1_pin_oe), .overflow_irq(overflow_irq), .chan_irq(chan_irq));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // Windows start mid-period, so a whole period of samples gives the duty regardless of phase
   task automatic measure(input int n);
      h0 = 0;
      h1 = 0;
      repeat (n) begin
         @(negedge ref_clk);
         h0 += (chan0_pin === 1'b1);
         h1 += (chan1_pin === 1'b1);
      end
      // Hand back on a rising edge so the next bus request starts right after it
      @(posedge ref_clk);
   endtask

   // Rewrites are not synchronised here; two spans of warm-up absorb the disturbance
   task automatic settle();
      measure(2 * span);
      measure(span);
   endtask

   function automatic int model_high(int v, int p, bit set_edge, bit tov, bit full);
      if (!tov) begin
         return set_edge ? p + 1 : 0;
      end
      if (full) begin
         return p + 1;
      end
      return set_edge ? p + 1 - v : v;
   endfunction

   initial begin
      #1000000;
      n_errors++;
      test_done();
   end

   initial begin
      void'($urandom(32'h91DC4039));
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, timer_pkg::OFS_TIMER_CTRL, 32'h0);
      check("ctrl_reset", rd, 32'h20);
      apb(1'b0, timer_pkg::OFS_PERIOD, 32'h0);
      check("period_reset", rd, 32'hFFFF);
      apb(1'b0, 8'h1C, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      for (int ps = 0; ps < 7; ps++) begin
         per = $urandom_range(20, 3);
         v0 = $urandom_range(per, 0);
         v1 = $urandom_range(per, 0);
         apb(1'b1, timer_pkg::OFS_TIMER_CTRL, 32'h30);
         apb(1'b0, timer_pkg::OFS_COUNTER, 32'h0);
         check("count_cleared", rd, 32'h0);
         apb(1'b0, timer_pkg::OFS_COUNTER, 32'h0);
         check("count_halted", rd, 32'h0);
         apb(1'b0, timer_pkg::OFS_TIMER_CTRL, 32'h0);
         // Overflow flag of the previous run stays set until the read-then-write clear below
         check("reset_bit_zero", rd, (ps == 0) ? 32'h20 : 32'hA0);
         apb(1'b1, timer_pkg::OFS_PERIOD, per);
         apb(1'b1, timer_pkg::OFS_CH0_VALUE, v0);
         apb(1'b1, timer_pkg::OFS_CH1_VALUE, v1);
         apb(1'b1, timer_pkg::OFS_CH0_CTRL, 32'h5A);
         apb(1'b1, timer_pkg::OFS_CH1_CTRL, 32'h5E);
         apb(1'b1, timer_pkg::OFS_TIMER_CTRL, 32'h40 | ps);
         span = (per + 1) << ps;
         settle();
         check("ch0_high", h0, model_high(v0, per, 1'b0, 1'b1, 1'b0) << ps);
         check("ch1_high", h1, model_high(v1, per, 1'b1, 1'b1, 1'b0) << ps);
         check("pin_oe", {30'h0, chan1_pin_oe, chan0_pin_oe}, 32'h3);
         check("ovf_irq", {31'h0, overflow_irq}, 32'h1);
         check("chan_irq", {30'h0, chan_irq}, 32'h3);
      end
      apb(1'b0, timer_pkg::OFS_CH1_CTRL, 32'h0);
      check("ch1_ctrl", rd & 32'h3F, 32'h1E);
      apb(1'b1, timer_pkg::OFS_TIMER_CTRL, 32'h40);
      span = per + 1;
      for (int m = 0; m < 3; m++) begin
         ctl = (m == 0) ? 8'h18 : (m == 1) ? 8'h1B : 8'h1A;
         v0 = $urandom_range(per, 0);
         apb(1'b1, timer_pkg::OFS_CH0_VALUE, v0);
         apb(1'b1, timer_pkg::OFS_CH0_CTRL, ctl);
         settle();
         check("ch0_mode", h0, model_high(v0, per, 1'b0, ctl[1], ctl[0]));
      end
      apb(1'b1, timer_pkg::OFS_CH0_CTRL, 32'h3A);
      check("linked_oe", {30'h0, chan1_pin_oe, chan0_pin_oe}, 32'h1);
      apb(1'b0, timer_pkg::OFS_CH0_CTRL, 32'h0);
      check("linked_ctrl", rd & 32'h3F, 32'h3A);
      settle();
      check("linked_first", h0, v0);
      v1 = (v0 + 1 + $urandom_range(per - 1, 0)) % (per + 1);
      apb(1'b1, timer_pkg::OFS_CH1_VALUE, v1);
      settle();
      check("linked_ch1", h0, v1);
      v0 = (v1 + 1 + $urandom_range(per - 1, 0)) % (per + 1);
      apb(1'b1, timer_pkg::OFS_CH0_VALUE, v0);
      settle();
      check("linked_ch0", h0, v0);
      v0 = (v0 + 1) % (per + 1);
      apb(1'b1, timer_pkg::OFS_CH0_VALUE, v0);
      settle();
      check("linked_active", h0, v0);
      test_done();
   end
endmodule
`default_nettype wire
